// File: rtl/twsirq_regs.sv
// Interrupt mask, status clear, parameter and revision registers of the
// two-wire target, reached over APB. Assumes events and levels come from a
// protocol engine on the same pclk, so no synchroniser is needed.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Enable-set write ones set mask bits
// - Enable-clear write ones clear mask bits
// - Mask zero disables, one enables source
// - Only source bit positions exist; rest zero
// - Clear-port ones clear flag and request
// - Zeros ignored; levels never cleared here
// - Revision gives 12-bit version, no side effect
// - Variant field reserved, carries no behaviour
// - Parameter register reads zero, ignores writes
// - Each instance runs on its own pclk
// - Misplaced start/stop sets bus error flag
module twsirq_regs #(
   parameter logic [11:0] VERSION = 12'h0a5,  // Arbitrary value
   parameter logic [3:0]  VARIANT = 4'h0      // Arbitrary value
) (
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [twsirq_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Protocol engine side
   input  wire twsirq_pkg::twsirq_events_t  events,
   input  wire twsirq_pkg::twsirq_levels_t  levels,
   // Interrupt request
   output logic                             irq
);
   import twsirq_pkg::*;

   /////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] mask;          // Interrupt mask
   logic [31:0] flags;         // Sticky status flags
   logic [31:0] event_image;   // Events placed at their status positions
   logic [31:0] level_image;   // Levels placed at their status positions
   logic [31:0] status_view;   // What a status read returns
   logic [31:0] next_rdata;    // Read data chosen at setup
   logic        next_err;      // Decode error chosen at setup
   logic        setup;         // Setup phase of a transfer
   logic        access;        // Completing access phase
   logic        wr_set;        // Write to enable-set port
   logic        wr_clr;        // Write to enable-clear port
   logic        wr_flag_clr;   // Write to flag clear port
   logic [31:0] flag_clr;      // Bits that a clear write removes
   logic [31:0] pwdata_q;      // Write data one cycle back, for checks
   logic [31:0] ev_q;          // Event image one cycle back, for checks

   /////////////////////////////////////////////////////////////////////////////
   // Bus phases

   // No wait states: data is prepared in setup, so access ends at once
   assign setup  = psel && !penable;
   assign pready = psel && penable;
   assign access = psel && penable;

   // Partial strobes are ignored on the write-one ports: a narrow write
   // could otherwise set or clear bits that software did not mean to touch
   assign wr_set      = access && pwrite && (&pstrb) && (paddr == OFS_IRQ_ENABLE_SET);
   assign wr_clr      = access && pwrite && (&pstrb) && (paddr == OFS_IRQ_ENABLE_CLR);
   assign wr_flag_clr = access && pwrite && (&pstrb) && (paddr == OFS_FLAG_CLEAR_PORT);

   /////////////////////////////////////////////////////////////////////////////
   // Status images

   // Scatter event pulses to their flag positions
   assign event_image = {8'h00,
                         events.byte_done, events.restart_seen,
                         events.end_condition_seen, events.smbus_default_addr_hit,
                         events.smbus_host_header_hit, events.smbus_alert_response_hit,
                         events.general_call_hit, events.own_address_hit,
                         1'b0,
                         events.misplaced_condition_error, events.smbus_checksum_error,
                         events.smbus_time_limit_error,
                         3'b000,
                         events.nak_received,
                         events.receive_overflow, events.transmit_starved,
                         2'b00,
                         events.transaction_finished,
                         3'b000};

   // Levels are shown live and are not sticky
   always_comb begin
      level_image = READ_ZERO;
      level_image[POS_RX_FULL]   = levels.receive_holding_full;
      level_image[POS_TX_EMPTY]  = levels.send_holding_empty;
      level_image[POS_ENABLED]   = levels.target_enabled;
      level_image[POS_DIRECTION] = levels.direction_is_send;
   end

   assign status_view = flags | level_image;

   /////////////////////////////////////////////////////////////////////////////
   // Interrupt mask

   // Set and clear ports sit at different addresses, so they never collide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= MASK_RESET;
      end else begin
         mask <= (mask | ({32{wr_set}} & pwdata))
                 & ~({32{wr_clr}} & pwdata) & IRQ_SRC_BITS;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Sticky flags

   assign flag_clr = {32{wr_flag_clr}} & pwdata & CLEARABLE_BITS;

   // A set in the same cycle as a clear is kept, so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= FLAGS_RESET;
      end else begin
         flags <= ((flags & ~flag_clr) | event_image) & CLEARABLE_BITS;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Interrupt request

   // Registered so the output is glitch-free; costs one cycle of latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_view & mask);
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Read decode

   // Write-only ports read as zero; unknown offsets report an error
   always_comb begin
      next_rdata = READ_ZERO;
      next_err   = 1'b0;
      unique case (paddr)
         OFS_FLAG_STATUS: begin
            next_rdata = status_view;
         end
         OFS_IRQ_MASK: begin
            next_rdata = mask;
         end
         OFS_IRQ_ENABLE_SET, OFS_IRQ_ENABLE_CLR, OFS_FLAG_CLEAR_PORT: begin
            next_rdata = READ_ZERO;
         end
         OFS_PARAMETER_INFO: begin
            next_rdata = PARAMETER_INFO;
         end
         OFS_MODULE_REVISION: begin
            next_rdata = READ_ZERO;
            next_rdata[REV_VER_LSB +: 12] = VERSION;
            next_rdata[REV_VAR_LSB +: 4]  = VARIANT;
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
   end

   // Captured in setup so data is stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= READ_ZERO;
      end else if (setup) begin
         prdata <= pwrite ? READ_ZERO : next_rdata;
      end
   end

   // Error flag for the coming access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= next_err;
      end
   end

   // single pclk domain per instance; gating done outside

   /////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // A completed write to a given offset
   sequence s_write_at(logic [ADDR_W-1:0] ofs);
      psel && penable && pwrite && (&pstrb) && (paddr == ofs);
   endsequence

   // A read setup followed by its access phase at a given offset
   sequence s_read_at(logic [ADDR_W-1:0] ofs);
      (psel && !penable && !pwrite && (paddr == ofs)) ##1 (psel && penable);
   endsequence

   a_mask_set_bits: assert property (
      s_write_at(OFS_IRQ_ENABLE_SET)
      |=> ((mask & pwdata_q & IRQ_SRC_BITS) == (pwdata_q & IRQ_SRC_BITS)))
      else $error("mask bit not set by enable-set write");

   a_mask_clr_bits: assert property (
      s_write_at(OFS_IRQ_ENABLE_CLR) |=> ((mask & pwdata_q) == READ_ZERO))
      else $error("mask bit not cleared by enable-clear write");

   a_mask_reserved: assert property (
      (mask & ~IRQ_SRC_BITS) == READ_ZERO)
      else $error("unimplemented mask bit set");

   a_irq_gating: assert property (
      ##1 (irq == $past(|(status_view & mask))))
      else $error("interrupt does not follow masked status");

   a_irq_off_masked: assert property (
      (mask == READ_ZERO) [*2] |-> !irq)
      else $error("interrupt raised with all sources masked");

   a_flag_clear_one: assert property (
      s_write_at(OFS_FLAG_CLEAR_PORT)
      |=> ((flags & pwdata_q & CLEARABLE_BITS & ~ev_q) == READ_ZERO))
      else $error("flag not cleared by clear-port write");

   a_flag_keep: assert property (
      !wr_flag_clr
      |=> ((flags & $past(flags)) == $past(flags)))
      else $error("flag lost without a clear write");

   a_set_wins: assert property (
      (wr_flag_clr && |(event_image & pwdata))
      |=> ((flags & ev_q) == ev_q))
      else $error("event lost against a clear write");

   a_bus_error_flag: assert property (
      events.misplaced_condition_error |=> flags[14])
      else $error("bus error event did not set its flag");

   a_revision_read: assert property (
      s_read_at(OFS_MODULE_REVISION) |-> (prdata[11:0] == VERSION && !pslverr))
      else $error("revision read returns wrong version");

   a_param_zero: assert property (
      s_read_at(OFS_PARAMETER_INFO) |-> (prdata == PARAMETER_INFO))
      else $error("parameter register not zero");

   // Zeros on the set port leave enabled sources enabled
   a_set_keeps_mask: assert property (
      s_write_at(OFS_IRQ_ENABLE_SET) |=> ((mask & $past(mask)) == $past(mask)))
      else $error("enable-set write dropped a mask bit");

   // The clear port can only take bits away
   a_clr_only_clears: assert property (
      s_write_at(OFS_IRQ_ENABLE_CLR) |=> ((mask | $past(mask)) == $past(mask)))
      else $error("enable-clear write set a mask bit");

   // Mask only moves on its own set and clear ports; a write to the
   // read-only mask offset or a narrow strobe must leave it alone
   a_mask_holds: assert property (
      !(wr_set || wr_clr) |=> $stable(mask))
      else $error("mask changed without a set or clear write");

   // Level indications never latch: the sticky store holds sources only
   a_flags_sticky_only: assert property (
      (flags & ~CLEARABLE_BITS) == READ_ZERO)
      else $error("level bit held in the sticky store");

   // Bits written as zero on the clear port keep their flags
   a_zero_clear_keeps: assert property (
      s_write_at(OFS_FLAG_CLEAR_PORT)
      |=> ((flags & ~pwdata_q & $past(flags)) == (~pwdata_q & $past(flags))))
      else $error("flag lost on a zero bit of a clear write");

   // Every event pulse lands in its flag, with or without a clear write
   a_event_lands: assert property (
      (event_image != READ_ZERO) |=> ((flags & ev_q) == ev_q))
      else $error("event pulse did not set its flag");

   // A clear write that leaves no enabled source behind
   sequence s_clear_leaves_none;
      s_write_at(OFS_FLAG_CLEAR_PORT) ##1 ((status_view & mask) == READ_ZERO);
   endsequence

   // The request must drop one edge after its last source went away;
   // software relies on this to leave its handler without a re-entry
   a_irq_withdrawn: assert property (
      s_clear_leaves_none |=> !irq)
      else $error("request stays after its flags were cleared");

   // An enabled sticky flag that stays set must show on the request
   a_irq_follows_flag: assert property (
      (|(flags & mask)) [*2] |-> irq)
      else $error("enabled flag held but no request");

   // Variant is passed through untouched; it carries no behaviour
   a_rev_variant: assert property (
      s_read_at(OFS_MODULE_REVISION) |-> (prdata[REV_VAR_LSB +: 4] == VARIANT))
      else $error("revision read returns wrong variant");

   // Parameter register is a plain read, never an error
   a_param_no_err: assert property (
      s_read_at(OFS_PARAMETER_INFO) |-> !pslverr)
      else $error("parameter read reports an error");

   // The clear port is write-only, so a read of it shows nothing
   a_clear_reads_zero: assert property (
      s_read_at(OFS_FLAG_CLEAR_PORT) |-> (prdata == READ_ZERO))
      else $error("clear port read returns data");

   // Helpers: write data and events one cycle back, so a consequent can
   // still see what the antecedent cycle carried
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwdata_q <= READ_ZERO;
         ev_q     <= READ_ZERO;
      end else begin
         pwdata_q <= pwdata;
         ev_q     <= event_image;
      end
   end

endmodule

// File: rtl/twsirq_pkg.sv
// Package for the two-wire target interrupt and identity register bank.
// Assumes an APB slave with 32-bit data and byte addresses in an 8-bit window.
package twsirq_pkg;

   // APB address width seen by the bank
   localparam int unsigned ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_FLAG_STATUS     = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET  = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLR  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK        = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_FLAG_CLEAR_PORT = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_PARAMETER_INFO  = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_MODULE_REVISION = 8'h30;

   // Bits that exist as interrupt sources (mask and status share them)
   localparam logic [31:0] IRQ_SRC_BITS   = 32'h00ff_71cb;
   // Sticky bits that the clear port may clear
   localparam logic [31:0] CLEARABLE_BITS = 32'h00ff_71c8;

   // Reset and fixed values
   localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
   localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
   localparam logic [31:0] PARAMETER_INFO = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

   // Level indication bit positions in the status image
   localparam int unsigned POS_RX_FULL   = 0;
   localparam int unsigned POS_TX_EMPTY  = 1;
   localparam int unsigned POS_ENABLED   = 2;
   localparam int unsigned POS_DIRECTION = 5;

   // Revision field positions
   localparam int unsigned REV_VER_LSB = 0;
   localparam int unsigned REV_VAR_LSB = 16;

   // One-cycle event pulses from the protocol engine, high bit first
   typedef struct packed {
      logic byte_done;
      logic restart_seen;
      logic end_condition_seen;
      logic smbus_default_addr_hit;
      logic smbus_host_header_hit;
      logic smbus_alert_response_hit;
      logic general_call_hit;
      logic own_address_hit;
      logic misplaced_condition_error;
      logic smbus_checksum_error;
      logic smbus_time_limit_error;
      logic nak_received;
      logic receive_overflow;
      logic transmit_starved;
      logic transaction_finished;
   } twsirq_events_t;

   // Live levels from the protocol engine
   typedef struct packed {
      logic direction_is_send;
      logic target_enabled;
      logic send_holding_empty;
      logic receive_holding_full;
   } twsirq_levels_t;

endpackage

// File: verif/twsirq_regs_tb.sv
// Self-checking bench for the two-wire target interrupt register bank.
// Assumes the bank answers APB with zero or more wait states on one pclk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module twsirq_regs_tb;
   import twsirq_pkg::*;

   // Identity values handed to the bank, arbitrary
   localparam logic [11:0] TB_VERSION = 12'h3c7;
   localparam logic [3:0]  TB_VARIANT = 4'h2;
   // Level bits as they appear in the status image
   localparam logic [31:0] LVL = 32'h1 << POS_RX_FULL | 32'h1 << POS_TX_EMPTY |
                                 32'h1 << POS_ENABLED | 32'h1 << POS_DIRECTION;

   // Bench signals
   logic              pclk;
   logic              presetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [3:0]        pstrb;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              irq;
   twsirq_events_t    events;
   twsirq_levels_t    levels;
   twsirq_events_t    ev_one;    // Single byte_done pulse image
   logic [31:0]       rd;        // Last read word
   logic              err;       // Last error response
   int                mismatches;
   int                checked;

   twsirq_regs #(.VERSION(TB_VERSION), .VARIANT(TB_VARIANT)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .events(events), .levels(levels), .irq(irq));

   // Free-running bus clock, 40 ns period
   always #20 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, the only place the run ends
   task test_done;
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task cmp1(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   // One APB transfer; the wait for pready is bounded so a hang ends the run
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         $display("mismatch %0t apb wait timed out", $time);
         test_done();
      end
   endtask

   task rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      cmp32(rd, exp, what);
      cmp1(err, 1'b0, what);
   endtask

   task settle;
      repeat (2) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Reset values, identity and an unmapped offset
   task t_reset;
      rd_chk(OFS_IRQ_MASK, MASK_RESET, "mask reset");
      rd_chk(OFS_PARAMETER_INFO, PARAMETER_INFO, "param reset");
      rd_chk(OFS_FLAG_CLEAR_PORT, READ_ZERO, "clear port reads zero");
      rd_chk(OFS_MODULE_REVISION, {12'h000, TB_VARIANT, 4'h0, TB_VERSION}, "rev");
      apb(1'b0, 8'h34, 32'h0000_0000);
      cmp1(err, 1'b1, "unmapped error");
      cmp1(irq, 1'b0, "irq after reset");
   endtask

   // Mask set and clear ports, only source bits exist
   task t_mask;
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'hffff_ffff);
      rd_chk(OFS_IRQ_MASK, IRQ_SRC_BITS, "mask all set");
      apb(1'b1, OFS_IRQ_ENABLE_CLR, 32'h0000_f00f);
      rd_chk(OFS_IRQ_MASK, IRQ_SRC_BITS & ~32'h0000_f00f, "mask part clr");
      apb(1'b1, OFS_IRQ_ENABLE_CLR, 32'hffff_ffff);
      rd_chk(OFS_IRQ_MASK, 32'h0000_0000, "mask all clr");
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_4000);
      rd_chk(OFS_IRQ_MASK, 32'h0000_4000, "mask one set");
      apb(1'b1, OFS_IRQ_ENABLE_CLR, 32'h0000_4000);
      pstrb <= 4'h1;
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_00ff);
      pstrb <= 4'hf;
      rd_chk(OFS_IRQ_MASK, 32'h0000_0000, "narrow set ignored");
   endtask

   // Every event sets its flag; clear port clears only sticky flags
   task t_flags;
      @(posedge pclk);
      levels <= '1;
      events <= '1;
      @(posedge pclk);
      events <= '0;
      rd_chk(OFS_FLAG_STATUS, CLEARABLE_BITS | LVL, "all flags set");
      cmp1(irq, 1'b0, "masked out");
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_4000);
      settle();
      cmp1(irq, 1'b1, "bus error irq");
      apb(1'b1, OFS_FLAG_CLEAR_PORT, 32'h0000_0000);
      rd_chk(OFS_FLAG_STATUS, CLEARABLE_BITS | LVL, "zero clear");
      apb(1'b1, OFS_FLAG_CLEAR_PORT, 32'hffff_ffff);
      rd_chk(OFS_FLAG_STATUS, LVL, "ones clear");
      settle();
      cmp1(irq, 1'b0, "irq withdrawn");
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0001);
      settle();
      cmp1(irq, 1'b1, "level irq");
      @(posedge pclk);
      levels <= '0;
      settle();
      cmp1(irq, 1'b0, "level gone");
      apb(1'b1, OFS_IRQ_ENABLE_CLR, 32'hffff_ffff);
   endtask

   // Event and clear on the same edge: the event is kept
   task t_race;
      int n;
      n = 0;
      apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0080_0000);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= 1'b1;
      paddr <= OFS_FLAG_CLEAR_PORT; pwdata <= 32'h0080_0000;
      @(posedge pclk);
      penable <= 1'b1;
      // Pulse held through the whole access phase so it meets the closing edge
      events <= ev_one;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      cmp1(pready, 1'b1, "clear on event edge");
      if (pready !== 1'b1) test_done();
      psel <= 1'b0; penable <= 1'b0; events <= '0;
      rd_chk(OFS_FLAG_STATUS, 32'h0080_0000, "set beats clear");
      settle();
      cmp1(irq, 1'b1, "race irq");
      apb(1'b1, OFS_FLAG_CLEAR_PORT, 32'h0080_0000);
      rd_chk(OFS_FLAG_STATUS, 32'h0000_0000, "race cleared");
   endtask

   // Writes to read-only places change nothing
   task t_ro;
      apb(1'b1, OFS_PARAMETER_INFO, 32'hffff_ffff);
      cmp1(err, 1'b0, "ro write no error");
      rd_chk(OFS_PARAMETER_INFO, 32'h0000_0000, "param after write");
      apb(1'b1, OFS_MODULE_REVISION, 32'hffff_ffff);
      apb(1'b1, OFS_IRQ_MASK, 32'hffff_ffff);
      rd_chk(OFS_MODULE_REVISION, {12'h000, TB_VARIANT, 4'h0, TB_VERSION}, "rev2");
      rd_chk(OFS_IRQ_MASK, 32'h0080_0000, "mask after rev reads");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; pstrb = 4'hf; events = '0; levels = '0;
      ev_one = '0;
      ev_one.byte_done = 1'b1;
      mismatches = 0;
      checked = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mask();
      t_flags();
      t_race();
      t_ro();
      test_done();
   end
endmodule
